// [design/speech_cmd_map.svh]
// Offsets, field positions, opcodes and timing figures of the command decoder
`ifndef SPEECH_CMD_MAP_SVH
`define SPEECH_CMD_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define REG_STATUS      8'h00
`define REG_PARAM       8'h04
`define REG_CTRL        8'h08
`define REG_WAVE_BASE   8'h0C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTRL_METHOD_RST 2'h0
`define CTRL_END_BIT    8

// ------------------------------------------------------------
// Opcodes (upper nibble of the first byte)
// ------------------------------------------------------------
`define OP_POWER_UP_FAST   4'h0
`define OP_POWER_UP_SOFT   4'h1
`define OP_POWER_DOWN_FAST 4'h2
`define OP_POWER_DOWN_SOFT 4'h3
`define OP_PLAY            4'h4
`define OP_STOP            4'h6
`define OP_SILENCE_INSERT  4'h7
`define OP_REPEAT_SET      4'h8
`define OP_REPEAT_CLEAR    4'h9
`define OP_LOUDNESS_SET    4'hA

// ------------------------------------------------------------
// Bank count codes and memory layout
// ------------------------------------------------------------
`define BANKS_ONE       2'h0
`define BANKS_TWO       2'h1
`define BANKS_FOUR      2'h2
`define BANKS_BAD       2'h3
`define CTRL_AREA_END   20'h007FF
`define WAVE_AREA_BASE  20'h00808

// ------------------------------------------------------------
// Timing: times in microseconds, clock in MHz; analog output levels
// ------------------------------------------------------------
`define CLK_MHZ         10
`define T_STAB_FAST_US  2000
`define T_STAB_SOFT_US  66000
`define T_FALL_FAST_US  6
`define T_FALL_SOFT_US  64000
`define T_ACK_US        6
`define ANALOG_WAVE_OUT_IDLE       12'h800
`define ANALOG_WAVE_OUT_GROUND     12'h000

`endif

// [design/speech_cmd_pkg.sv]
// Types shared by the serial command decoder
`default_nettype none
package speech_cmd_pkg;
	// Power state, Gray coded along down -> stab -> wait -> fall -> down
	typedef enum logic [1:0] {
		PS_DOWN = 2'b00,
		PS_STAB = 2'b01,
		PS_WAIT = 2'b11,
		PS_FALL = 2'b10
	} pwr_state_e;
	// What the next byte means
	typedef enum logic [1:0] {
		FOL_NONE    = 2'b00,
		FOL_PHRASE  = 2'b01,
		FOL_SILENCE = 2'b11
	} follow_e;
	// Waveform decoding methods
	typedef enum logic [1:0] {
		DEC_ADPCM4  = 2'b00,
		DEC_NLPCM8  = 2'b01,
		DEC_PCM8    = 2'b10,
		DEC_PCM16   = 2'b11
	} decode_method_e;
	// Serial link pins from the host
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic serial_cmd_in;
		logic edge_polarity_select;
	} serial_pins_s;
	// Memory bank pins
	typedef struct packed {
		logic bank_pin_hi;
		logic bank_pin_lo;
	} bank_pins_s;
endpackage
`default_nettype wire

// [design/speech_serial_command_decoder.sv]
// Serial command input, decoder and power sequencing with an APB register port
`timescale 1ns/1ns
`default_nettype none
`include "speech_cmd_map.svh"

// Operation
// - Serial bits taken only while select low
// - Command executes on eighth selected edge
// - Polarity low: sample on rising edge
// - Polarity high: sample on falling edge
// - Select high resets edge count; back-to-back ok
// - Bytes of eight bits; two-byte play, silence
// - Nibble 0: fast power-up, latch bank count
// - Nibble 1: soft power-up, latch bank count
// - Nibble 2: fast power-down from wait
// - Nibble 3: soft power-down from wait
// - Nibble 4: next byte is phrase number
// - Nibble 6: stop, clears repeat mode
// - Nibble 7: next byte is silence length
// - Nibble 8: repeat set, only while playing
// - Nibble 9: repeat clear
// - Nibble A: latch four-bit loudness
// - Power down halts all activity
// - Reset, power down: outputs high, ground
// - Control area to 7FF, waves at 808
// - Four waveform decoding methods
// - Power down ignores all but power-up
// - Bank count: one, two, four, prohibited
// - Commands ignored during stabilisation
// - Both outputs high the cycle after power down
module speech_serial_command_decoder #(
	parameter int STAB_FAST_CYC = `T_STAB_FAST_US * `CLK_MHZ,
	parameter int STAB_SOFT_CYC = `T_STAB_SOFT_US * `CLK_MHZ,
	parameter int FALL_SOFT_CYC = `T_FALL_SOFT_US * `CLK_MHZ,
	parameter int TIMER_W       = 20
) (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Serial link and bank pins
	input  wire speech_cmd_pkg::serial_pins_s link_in,
	input  wire speech_cmd_pkg::bank_pins_s   bank_in,
	// Device outputs
	output logic                             command_accept_n,
	output logic                             busy_n,
	output logic      [11:0]                 analog_wave_out,
	output logic      [1:0]                  bank_select
);
	import speech_cmd_pkg::*;

	// Short timing counts that need no parameter
	localparam int FALL_FAST_CYC = `T_FALL_FAST_US * `CLK_MHZ;
	localparam int ACK_CYC       = `T_ACK_US * `CLK_MHZ;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [5:0]           sync1_r;      // First synchroniser stage
	logic [5:0]           sync2_r;      // Second synchroniser stage
	logic                 sck_prev_r;   // Delayed clean serial clock
	logic [2:0]           bit_cnt_r;    // Edges taken in this byte
	logic [6:0]           shift_r;      // Bits gathered so far
	logic                 byte_valid_r; // One-cycle byte strobe
	logic [7:0]           byte_r;       // Completed byte
	pwr_state_e           state_r;      // Power state
	logic [TIMER_W-1:0]   timer_r;      // Stabilise or fall timer
	follow_e              follow_r;     // Pending parameter byte
	logic                 playing_r;    // Phrase or silence active
	logic                 repeat_r;     // Repeat playback mode
	logic [1:0]           bank_cnt_r;   // Latched bank count
	logic [7:0]           phrase_r;     // Phrase number
	logic [7:0]           silence_r;    // Silence length
	logic [3:0]           loudness_r;   // Loudness level
	logic [$clog2(ACK_CYC+1)-1:0] ack_r; // Command accept low time
	decode_method_e       method_r;     // Decoding method
	logic                 end_evt_r;    // Software end-of-phrase pulse

	// Clean pin views
	logic cs_n_s, sck_s, din_s, pol_s, edge_hit, cmd_take;
	logic [3:0] op;
	assign cs_n_s   = sync2_r[5];
	assign sck_s    = sync2_r[4];
	assign din_s    = sync2_r[3];
	assign pol_s    = sync2_r[2];
	// Selected edge of the serial clock
	assign edge_hit = pol_s ? (sck_prev_r & ~sck_s)
	                        : (~sck_prev_r & sck_s);
	assign op       = byte_r[7:4];
	// Opcode byte seen in command wait
	assign cmd_take = byte_valid_r && state_r == PS_WAIT && follow_r == FOL_NONE;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two stages for every pin from outside
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r    <= 6'h3C;
			sync2_r    <= 6'h3C;
			sck_prev_r <= 1'b1;
		end else begin
			sync1_r    <= {link_in, bank_in};
			sync2_r    <= sync1_r;
			sck_prev_r <= sync2_r[4];
		end
	end

	// ------------------------------------------------------------
	// Serial shifter
	// ------------------------------------------------------------
	// Gathers bits MSB first, strobes the byte on the eighth edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_r    <= 3'h0;
			shift_r      <= 7'h00;
			byte_valid_r <= 1'b0;
			byte_r       <= 8'h00;
		end else begin
			byte_valid_r <= 1'b0;
			if (cs_n_s) begin
				// Deselect returns the edge count to its start
				bit_cnt_r <= 3'h0;
			end else if (edge_hit) begin
				shift_r   <= {shift_r[5:0], din_s};
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7) begin
					// Eighth edge completes the byte
					byte_valid_r <= 1'b1;
					byte_r       <= {shift_r, din_s};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	// Power up, stabilisation, wait, power down sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= PS_DOWN;
			timer_r <= '0;
		end else begin
			unique case (state_r)
				PS_DOWN: begin
					// Only power-up bytes wake the device
					if (byte_valid_r && op == `OP_POWER_UP_FAST) begin
						state_r <= PS_STAB;
						timer_r <= TIMER_W'(STAB_FAST_CYC - 1);
					end else if (byte_valid_r && op == `OP_POWER_UP_SOFT) begin
						state_r <= PS_STAB;
						timer_r <= TIMER_W'(STAB_SOFT_CYC - 1);
					end
				end
				PS_STAB: begin
					// All bytes ignored until stable
					if (timer_r == '0) begin
						state_r <= PS_WAIT;
					end else begin
						timer_r <= timer_r - TIMER_W'(1);
					end
				end
				PS_WAIT: begin
					if (cmd_take && op == `OP_POWER_DOWN_FAST) begin
						state_r <= PS_FALL;
						timer_r <= TIMER_W'(FALL_FAST_CYC - 1);
					end else if (cmd_take && op == `OP_POWER_DOWN_SOFT) begin
						state_r <= PS_FALL;
						timer_r <= TIMER_W'(FALL_SOFT_CYC - 1);
					end
				end
				PS_FALL: begin
					// Outputs return high the cycle after the move to power down
					if (timer_r == '0) begin
						state_r <= PS_DOWN;
					end else begin
						timer_r <= timer_r - TIMER_W'(1);
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Command fields
	// ------------------------------------------------------------
	// Bank count from the power-up byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_cnt_r <= `BANKS_ONE;
		end else if (byte_valid_r && state_r == PS_DOWN && op[3:1] == 3'h0 &&
		             byte_r[1:0] != `BANKS_BAD) begin
			// Prohibited count keeps the old setting
			bank_cnt_r <= byte_r[1:0];
		end
	end

	// Two-byte tracking and parameter capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			follow_r  <= FOL_NONE;
			phrase_r  <= 8'h00;
			silence_r <= 8'h00;
		end else if (state_r != PS_WAIT) begin
			follow_r <= FOL_NONE;
		end else if (byte_valid_r && follow_r == FOL_PHRASE) begin
			phrase_r <= byte_r;
			follow_r <= FOL_NONE;
		end else if (byte_valid_r && follow_r == FOL_SILENCE) begin
			silence_r <= byte_r;
			follow_r  <= FOL_NONE;
		end else if (cmd_take && op == `OP_PLAY) begin
			follow_r <= FOL_PHRASE;
		end else if (cmd_take && op == `OP_SILENCE_INSERT) begin
			follow_r <= FOL_SILENCE;
		end
	end

	// Playback and repeat flags; a start beats a same-cycle end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			playing_r <= 1'b0;
			repeat_r  <= 1'b0;
		end else if (state_r != PS_WAIT) begin
			playing_r <= 1'b0;
			repeat_r  <= 1'b0;
		end else if (byte_valid_r && follow_r != FOL_NONE) begin
			playing_r <= 1'b1;
		end else if (cmd_take && op == `OP_STOP) begin
			playing_r <= 1'b0;
			repeat_r  <= 1'b0;
		end else if (cmd_take && op == `OP_REPEAT_SET) begin
			repeat_r <= playing_r;
		end else if (cmd_take && op == `OP_REPEAT_CLEAR) begin
			repeat_r <= 1'b0;
		end else if (end_evt_r && !repeat_r) begin
			// Phrase end without repeat finishes playback
			playing_r <= 1'b0;
		end
	end

	// Loudness from the low nibble of its byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loudness_r <= 4'h0;
		end else if (cmd_take && op == `OP_LOUDNESS_SET) begin
			loudness_r <= byte_r[3:0];
		end
	end

	// Command accept low time after each parameter byte or opcode byte up to nibble A in wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_r <= '0;
		end else if (byte_valid_r && state_r == PS_WAIT &&
		             (follow_r != FOL_NONE || op <= `OP_LOUDNESS_SET)) begin
			ack_r <= ($clog2(ACK_CYC+1))'(ACK_CYC);
		end else if (ack_r != '0) begin
			ack_r <= ack_r - ($clog2(ACK_CYC+1))'(1);
		end
	end

	// ------------------------------------------------------------
	// Device outputs
	// ------------------------------------------------------------
	// Registered pins; high and ground while down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			command_accept_n <= 1'b1;
			busy_n           <= 1'b1;
			analog_wave_out  <= `ANALOG_WAVE_OUT_GROUND;
			bank_select      <= 2'h0;
		end else begin
			command_accept_n <= !(state_r == PS_STAB || state_r == PS_FALL || ack_r != '0);
			busy_n           <= !(state_r == PS_STAB || state_r == PS_FALL || playing_r);
			analog_wave_out  <= (state_r == PS_WAIT) ? `ANALOG_WAVE_OUT_IDLE : `ANALOG_WAVE_OUT_GROUND;
			// Bank from pins by latched count
			unique case (bank_cnt_r)
				`BANKS_TWO:  bank_select <= {1'b0, sync2_r[0]};
				`BANKS_FOUR: bank_select <= sync2_r[1:0];
				default:     bank_select <= 2'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Control register and end-of-phrase pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			method_r  <= decode_method_e'(`CTRL_METHOD_RST);
			end_evt_r <= 1'b0;
		end else begin
			end_evt_r <= 1'b0;
			if (psel && penable && pwrite && paddr == `REG_CTRL) begin
				method_r  <= decode_method_e'(pwdata[1:0]);
				end_evt_r <= pwdata[`CTRL_END_BIT];
			end
		end
	end

	// Read data captured in setup, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				pslverr <= 1'b0;
				unique case (paddr)
					`REG_STATUS:    prdata <= {19'h0, bank_select, bank_cnt_r,
					                          loudness_r, follow_r != FOL_NONE,
					                          repeat_r, playing_r, state_r};
					`REG_PARAM:     prdata <= {12'h000, loudness_r, silence_r, phrase_r};
					`REG_CTRL:      prdata <= {30'h0, method_r};
					`REG_WAVE_BASE: prdata <= {12'h000, `WAVE_AREA_BASE};
					default: begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_fall_done;
		state_r == PS_FALL && timer_r == '0;
	endsequence
	sequence s_down_quiet;
		state_r == PS_DOWN ##1 (command_accept_n && busy_n);
	endsequence

	chk_outputs_down_high: assert property (
		$past(state_r) == PS_DOWN |-> command_accept_n && busy_n &&
		analog_wave_out == `ANALOG_WAVE_OUT_GROUND)
		else $error("outputs not idle in power down");
	chk_eighth_edge: assert property (
		byte_valid_r |-> $past(bit_cnt_r) == 3'h7 && $past(edge_hit) && !$past(cs_n_s))
		else $error("byte strobe not on eighth edge");
	chk_deselect_clears: assert property (
		cs_n_s |=> bit_cnt_r == 3'h0 && !byte_valid_r)
		else $error("edge count kept through deselect");
	chk_power_up_wake: assert property (
		byte_valid_r && state_r == PS_DOWN && op == `OP_POWER_UP_FAST |=>
		state_r == PS_STAB ##1 !command_accept_n && !busy_n)
		else $error("power-up did not start stabilisation");
	chk_down_ignores: assert property (
		byte_valid_r && state_r == PS_DOWN && op > `OP_POWER_UP_SOFT |=>
		state_r == PS_DOWN && $stable(loudness_r))
		else $error("command acted in power down");
	chk_stab_ignores: assert property (
		state_r == PS_STAB |=> $stable(loudness_r) && $stable(follow_r) && !playing_r)
		else $error("command acted during stabilisation");
	chk_fall_to_down: assert property (
		s_fall_done |=> s_down_quiet)
		else $error("power down not reached with outputs high");
	chk_loudness_latch: assert property (
		cmd_take && op == `OP_LOUDNESS_SET |=> loudness_r == $past(byte_r[3:0]))
		else $error("loudness not latched");
	chk_stop_repeat: assert property (
		cmd_take && op == `OP_STOP |=> !repeat_r && !playing_r)
		else $error("stop left repeat or playback on");
	chk_repeat_playing: assert property (
		cmd_take && op == `OP_REPEAT_SET && !playing_r |=> !repeat_r)
		else $error("repeat set while idle");
	chk_param_byte: assert property (
		byte_valid_r && state_r == PS_WAIT && follow_r == FOL_PHRASE |=>
		phrase_r == $past(byte_r) && playing_r && follow_r == FOL_NONE)
		else $error("phrase byte not taken as parameter");
	chk_undefined_op: assert property (
		cmd_take && op > `OP_LOUDNESS_SET |=> $stable(state_r) && $stable(loudness_r) &&
		$stable(repeat_r) && follow_r == FOL_NONE)
		else $error("undefined opcode changed state");
endmodule
`default_nettype wire

// [tb/serial_host_model.sv]
// Host model that drives the four-wire serial command link
`timescale 1ns/1ns
`default_nettype none
module serial_host_model
	import speech_cmd_pkg::*;
(
	// Pacing clock
	input  wire logic                        pclk,
	// Link pins towards the decoder
	output var  speech_cmd_pkg::serial_pins_s link_out
);
	// -----------------------------------------
	// Link timing
	// -----------------------------------------
	localparam int HALF = 4; // Half of the 800 ns link period

	// Deselected, clock parked low
	initial link_out = 4'b1000;

	// Let n clock edges pass
	task automatic pause(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One frame of nbits bits; clock still outside it
	task automatic send(input logic [15:0] d, input int nbits, input logic pol);
		logic last;
		last = 1'b0;
		@(posedge pclk);
		link_out.edge_polarity_select <= pol;
		link_out.sck <= pol; // Park at the non-sampling level
		pause(HALF);
		link_out.cs_n <= 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			pause(HALF);
			link_out.serial_cmd_in <= d[i];
			link_out.sck <= pol;
			last = d[i];
			pause(HALF);
			link_out.sck <= ~pol; // Sampling edge
		end
		pause(HALF);
		link_out.sck <= pol;
		pause(HALF);
		link_out.cs_n <= 1'b1;
		link_out.serial_cmd_in <= ~last; // Released line keeps no stale bit
	endtask
endmodule
`default_nettype wire

// [tb/test_speech_serial_command_decoder.sv]
// Self-checking bench for the serial command decoder
`timescale 1ns/1ns
`default_nettype none
`include "speech_cmd_map.svh"
module test_speech_serial_command_decoder;
	import speech_cmd_pkg::*;
	// -----------------------------------------
	// Signals
	// -----------------------------------------
	logic         pclk;
	logic         presetn;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [7:0]   paddr;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	serial_pins_s link;
	bank_pins_s   bank;
	logic         command_accept_n;
	logic         busy_n;
	logic [11:0]  analog_wave_out;
	logic [1:0]   bank_select;
	int           bad_count;
	int           cmp_count;
	logic [31:0]  rd;
	logic         err;
	logic [31:0]  snap;
	logic [3:0]   undef [6];

	// Device with short stabilise and fall counts
	speech_serial_command_decoder #(
		.STAB_FAST_CYC(50),
		.STAB_SOFT_CYC(80),
		.FALL_SOFT_CYC(70)
	) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_in(link), .bank_in(bank),
		.command_accept_n(command_accept_n), .busy_n(busy_n),
		.analog_wave_out(analog_wave_out), .bank_select(bank_select)
	);

	// Host on the serial link
	serial_host_model host (.pclk(pclk), .link_out(link));

	// 100 ns clock
	always #50 pclk = ~pclk;

	// -----------------------------------------
	// Tasks
	// -----------------------------------------
	// Verdict and end of run
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; read data into rd, error into err
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Status word into rd
	task automatic stat();
		apb(1'b0, `REG_STATUS, 32'h0);
	endtask

	// Send a frame, then wait until the accept output is back high
	task automatic cmd(input logic [15:0] d, input int nb, input logic pol);
		int n;
		n = 0;
		host.send(d, nb, pol);
		repeat (8) @(posedge pclk);
		while (command_accept_n !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 300) begin
			bad_count++;
			results();
		end
	endtask

	// End-of-test line
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// Hang guard
	initial begin
		#2000000;
		bad_count++;
		results();
	end

	// -----------------------------------------
	// Main sequence
	// -----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		bank = 2'b01;
		bad_count = 0;
		cmp_count = 0;
		undef = '{4'h5, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check(command_accept_n, 32'h1);
		check(busy_n, 32'h1);
		check(analog_wave_out, `ANALOG_WAVE_OUT_GROUND);
		stat();
		check(rd[1:0], 32'h0);
		apb(1'b0, `REG_WAVE_BASE, 32'h0);
		check(rd, `WAVE_AREA_BASE);
		apb(1'b0, 8'h10, 32'h0);
		check({rd[30:0], err}, 32'h1);
		done("reset");
		// Commands other than power-up are dropped while down
		cmd({8'h00, `OP_LOUDNESS_SET, 4'h5}, 8, 1'b0);
		cmd({8'h00, `OP_STOP, 4'h0}, 8, 1'b0);
		stat();
		check(rd[8:0], 32'h0);
		check(command_accept_n, 32'h1);
		done("down_ignore");
		// Fast power-up, rising edges, two banks
		host.send({8'h00, `OP_POWER_UP_FAST, 4'h1}, 8, 1'b0);
		check({command_accept_n, busy_n}, 32'h0);
		cmd(16'h0005, 3, 1'b0); // Partial byte, dropped on deselect
		stat();
		check(rd[1:0], 32'h3);
		check(rd[10:9], `BANKS_TWO);
		check(bank_select, 32'h1);
		check(analog_wave_out, `ANALOG_WAVE_OUT_IDLE);
		done("power_up_fast");
		// Loudness on falling edges; repeat ignored when idle
		cmd({8'h00, `OP_LOUDNESS_SET, 4'h9}, 8, 1'b1);
		cmd({8'h00, `OP_REPEAT_SET, 4'h0}, 8, 1'b1);
		stat();
		check(rd[8:5], 32'h9);
		check(rd[3], 32'h0);
		apb(1'b0, `REG_PARAM, 32'h0);
		check(rd[19:16], 32'h9);
		done("loudness");
		// Two bytes in one frame start a phrase
		cmd({`OP_PLAY, 4'h3, 8'h2C}, 16, 1'b0);
		stat();
		check(rd[4:2], 32'h1);
		check(busy_n, 32'h0);
		apb(1'b0, `REG_PARAM, 32'h0);
		check(rd[7:0], 32'h2C);
		cmd({8'h00, `OP_REPEAT_SET, 4'hF}, 8, 1'b0);
		stat();
		check(rd[3], 32'h1);
		apb(1'b1, `REG_CTRL, 32'h100);
		stat();
		check(rd[3:2], 32'h3);
		cmd({8'h00, `OP_STOP, 4'h0}, 8, 1'b0);
		stat();
		check(rd[3:2], 32'h0);
		done("play_stop");
		// Repeat clear leaves playback running
		cmd({`OP_PLAY, 4'h0, 8'h07}, 16, 1'b1);
		cmd({8'h00, `OP_REPEAT_SET, 4'h0}, 8, 1'b1);
		cmd({8'h00, `OP_REPEAT_CLEAR, 4'hF}, 8, 1'b1);
		stat();
		check(rd[3:2], 32'h1);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, `REG_CTRL, m);
			apb(1'b0, `REG_CTRL, 32'h0);
			check(rd[1:0], m);
		end
		// Phrase end without repeat finishes playback
		apb(1'b1, `REG_CTRL, 32'h100);
		stat();
		check(rd[3:2], 32'h0);
		check(busy_n, 32'h1);
		done("repeat_methods");
		// Silence length byte
		cmd({`OP_SILENCE_INSERT, 4'h0, 8'h5A}, 16, 1'b0);
		apb(1'b0, `REG_PARAM, 32'h0);
		check(rd[15:8], 32'h5A);
		stat();
		snap = rd;
		foreach (undef[i]) begin
			cmd({8'h00, undef[i], 4'h3}, 8, 1'b0);
			stat();
			check(rd, snap);
		end
		done("silence_undefined");
		// Fast power-down, soft power-up with four banks, soft power-down
		cmd({8'h00, `OP_POWER_DOWN_FAST, 4'hF}, 8, 1'b0);
		stat();
		check(rd[1:0], 32'h0);
		check({busy_n, analog_wave_out}, 32'h1000);
		bank <= 2'b10;
		host.send({8'h00, `OP_POWER_UP_SOFT, 4'h2}, 8, 1'b1);
		cmd({8'h00, `OP_LOUDNESS_SET, 4'h3}, 8, 1'b1); // Lands in stabilisation
		stat();
		check(rd[1:0], 32'h3);
		check(rd[8:5], 32'h9);
		check(rd[10:9], `BANKS_FOUR);
		check(bank_select, 32'h2);
		cmd({8'h00, `OP_POWER_DOWN_SOFT, 4'hC}, 8, 1'b1);
		stat();
		check(rd[1:0], 32'h0);
		done("power_cycle");
		// Reset during stabilisation forces power down at once
		host.send({8'h00, `OP_POWER_UP_FAST, 4'h0}, 8, 1'b0);
		check({command_accept_n, busy_n}, 32'h0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check({command_accept_n, busy_n}, 32'h3);
		stat();
		check(rd[1:0], 32'h0);
		check(analog_wave_out, `ANALOG_WAVE_OUT_GROUND);
		done("reset_in_stab");
		results();
	end
endmodule
`default_nettype wire
